// *** hw/ocgp_port.v ***
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ocgp_consts.vh"
// ****************************************
// Five-bit port shared with oscillator pins
// ****************************************
module ocgp_port #(
  parameter WIDTH = `OCGP_WIDTH
) (
  input wire ref_clk,
  input wire rst,
  input wire hsel,
  input wire [15:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe_n,
  output reg filter_pullup,
  output reg crystal_osc_en,
  output reg ceramic_osc_en,
  input wire vco_clk
);
  // ****************************************
  // Registers
  // ****************************************
  reg [WIDTH-1:0] port_c_output_latch;
  reg [WIDTH-1:0] port_c_direction;
  reg port_c_function_select;
  reg [7:0] oscillator_control_reg;
  reg [1:0] power_mode;
  reg [1:0] prev_mode;
  reg [WIDTH-1:0] frozen_out;
  reg [WIDTH-1:0] frozen_oe_n;
  reg frozen_pull;
  reg frozen_xt;
  reg [WIDTH-1:0] sampled_pins;

  wire wr_en;
  wire [15:0] wr_addr;
  wire [15:0] rd_addr;

  ocgp_ahb_slave u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .rd_addr_now(rd_addr)
  );

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_c_output_latch <= `OCGP_RST_LATCH;
      port_c_direction <= `OCGP_RST_DIRECTION;
      port_c_function_select <= `OCGP_RST_FSEL;
      oscillator_control_reg <= `OCGP_RST_OSC_CTRL;
      power_mode <= `OCGP_MODE_RUN;
    end else if (wr_en) begin
      case (wr_addr)
        `OCGP_ADDR_LATCH: begin
          port_c_output_latch <= hwdata[WIDTH-1:0];
        end
        `OCGP_ADDR_DIRECTION: begin
          port_c_direction <= hwdata[WIDTH-1:0];
        end
        `OCGP_ADDR_FUNC_SEL: begin
          port_c_function_select <= hwdata[`OCGP_FSEL_BIT];
        end
        `OCGP_ADDR_OSC_CTRL: begin
          oscillator_control_reg <= hwdata[7:0];
        end
        `OCGP_ADDR_MODE: begin
          power_mode <= hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Oscillator selections and mode decode
  // ****************************************
  wire xt_sel = oscillator_control_reg[`OCGP_OSC_XT_A] &
    oscillator_control_reg[`OCGP_OSC_XT_B];
  wire cf_sel = oscillator_control_reg[`OCGP_OSC_CF_A] &
    oscillator_control_reg[`OCGP_OSC_CF_B] &
    oscillator_control_reg[`OCGP_OSC_CF_C];
  wire in_halt = (power_mode == `OCGP_MODE_HALT);
  wire in_hold = (power_mode == `OCGP_MODE_HOLD);
  wire in_deep = (power_mode == `OCGP_MODE_DEEP);
  wire entering = (power_mode != prev_mode) & (power_mode != `OCGP_MODE_RUN);
  // Crystal stays oscillating in deep hold only if selected at entry
  wire xt_active = xt_sel & ~in_hold & ~(in_deep & ~frozen_xt);
  wire cf_active = cf_sel & ~in_hold & ~in_deep;

  // ****************************************
  // Per-pin general-purpose decode
  // ****************************************
  wire [WIDTH-1:0] gp_drive_n;
  wire [WIDTH-1:0] gp_level;
  wire [WIDTH-1:0] gp_pull;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      ocgp_pin_cell u_cell (
        .latch(port_c_output_latch[gi]),
        .dir(port_c_direction[gi]),
        .pull_capable(gi == 2),
        .drive_n(gp_drive_n[gi]),
        .level(gp_level[gi]),
        .pull(gp_pull[gi])
      );
    end
  endgenerate

  reg [WIDTH-1:0] next_out;
  reg [WIDTH-1:0] next_oe_n;
  reg next_pull;
  always @* begin
    next_out = gp_level;
    next_oe_n = gp_drive_n;
    next_pull = gp_pull[2];
    // Function select on the VCO pin: latch 0 gives the VCO clock
    if (port_c_function_select & port_c_direction[4] & ~port_c_output_latch[4]) begin
      next_out[4] = vco_clk;
    end
    if (xt_active) begin
      next_out[1:0] = 2'h0;
      next_oe_n[1:0] = 2'h3;
    end
    if (cf_active) begin
      next_out[4:3] = 2'h0;
      next_oe_n[4:3] = 2'h3;
    end
  end

  // ****************************************
  // Low-power retention and pin outputs
  // ****************************************
  // Gp outputs are frozen in hold modes; inputs and released pins follow live
  wire xt_keep = xt_sel & in_deep & frozen_xt;
  wire [WIDTH-1:0] released = {{2{cf_sel}}, 1'b0, {2{xt_sel & in_hold}}};
  wire [WIDTH-1:0] keep_hold = (~port_c_direction | released) &
    ~{3'h0, {2{xt_keep}}};
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_mode <= `OCGP_MODE_RUN;
      frozen_out <= 5'h00;
      frozen_oe_n <= 5'h1f;
      frozen_pull <= 1'b0;
      frozen_xt <= 1'b0;
      pin_out <= 5'h00;
      pin_oe_n <= 5'h1f;
      filter_pullup <= 1'b0;
      crystal_osc_en <= 1'b0;
      ceramic_osc_en <= 1'b0;
      sampled_pins <= 5'h00;
    end else begin
      prev_mode <= power_mode;
      sampled_pins <= pin_in;
      if (power_mode == `OCGP_MODE_RUN) begin
        frozen_out <= next_out;
        frozen_oe_n <= next_oe_n;
        frozen_pull <= next_pull;
        frozen_xt <= xt_sel;
      end
      if (in_halt) begin
        pin_out <= frozen_out;
        pin_oe_n <= frozen_oe_n;
        filter_pullup <= frozen_pull;
      end else if (in_hold | in_deep) begin
        pin_out <= (frozen_out & ~keep_hold) | (next_out & keep_hold);
        pin_oe_n <= (frozen_oe_n & ~keep_hold) | (next_oe_n & keep_hold);
        filter_pullup <= next_pull;
      end else begin
        pin_out <= next_out;
        pin_oe_n <= next_oe_n;
        filter_pullup <= next_pull;
      end
      crystal_osc_en <= in_halt ? crystal_osc_en : xt_active;
      ceramic_osc_en <= in_halt ? ceramic_osc_en : cf_active;
      if (entering) begin
        frozen_xt <= frozen_xt;
      end
    end
  end

  // ****************************************
  // Bus read data and response
  // ****************************************
  reg [31:0] next_rdata;
  always @* begin
    case (rd_addr)
      `OCGP_ADDR_LATCH: next_rdata = {27'h0, port_c_output_latch};
      `OCGP_ADDR_PIN_INPUT: next_rdata = {27'h0, sampled_pins};
      `OCGP_ADDR_DIRECTION: next_rdata = {27'h0, port_c_direction};
      `OCGP_ADDR_FUNC_SEL: next_rdata = {27'h0, port_c_function_select, 4'h0};
      `OCGP_ADDR_OSC_CTRL: next_rdata = {24'h0, oscillator_control_reg};
      `OCGP_ADDR_MODE: next_rdata = {30'h0, power_mode};
      default: next_rdata = 32'h0000_0000;
    endcase
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel & htrans[1] & hready & ~hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end
endmodule

// *** hw/ocgp_consts.vh ***
// Functional notes
// - Oscillator control bits 2 and 0 set: pins a and b oscillate, latch/direction ignored.
// - Filter pin: floats, pulls up, or drives latch by latch and direction.
// - Control bits 7, 3 and 1 set: ceramic pins oscillate, overriding all settings.
// - Function select: VCO pin floats, outputs VCO clock (latch 0) or high.
// - Pin input reading stays enabled in every non-oscillator configuration.
// - Halt mode freezes every pin in its state at entry.
// - Hold and deep hold keep general-purpose outputs as at entry.
// - Hold releases crystal pins from oscillation to general-purpose operation.
// - Deep hold keeps crystal pins in their state at entry.
// - Both hold modes return ceramic pins to general-purpose operation.
// - Pin-input read returns the current level of all five pins.
`ifndef OCGP_CONSTS_VH
`define OCGP_CONSTS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define OCGP_ADDR_LATCH 16'h7fd0
`define OCGP_ADDR_PIN_INPUT 16'h7fd1
`define OCGP_ADDR_DIRECTION 16'h7fd2
`define OCGP_ADDR_FUNC_SEL 16'h7fd3
`define OCGP_ADDR_OSC_CTRL 16'h7fd4
`define OCGP_ADDR_MODE 16'h7fd8
// ****************************************
// Field positions and reset values
// ****************************************
`define OCGP_WIDTH 5
`define OCGP_FSEL_BIT 4
`define OCGP_OSC_XT_A 2
`define OCGP_OSC_XT_B 0
`define OCGP_OSC_CF_A 7
`define OCGP_OSC_CF_B 3
`define OCGP_OSC_CF_C 1
`define OCGP_RST_LATCH 5'h00
`define OCGP_RST_DIRECTION 5'h00
`define OCGP_RST_FSEL 1'h0
`define OCGP_RST_OSC_CTRL 8'h00
// Mode register codes
`define OCGP_MODE_RUN 2'h0
`define OCGP_MODE_HALT 2'h1
`define OCGP_MODE_HOLD 2'h2
`define OCGP_MODE_DEEP 2'h3
`endif

// *** hw/ocgp_pin_cell.v ***
`timescale 1ns/1ps
`include "ocgp_consts.vh"
// One general-purpose pin decode: float, pull-up, drive latch
module ocgp_pin_cell (
  input wire latch,
  input wire dir,
  input wire pull_capable,
  output wire drive_n,
  output wire level,
  output wire pull
);
  assign drive_n = ~dir;
  assign level = latch;
  assign pull = pull_capable & ~dir & latch;
endmodule

// *** hw/ocgp_ahb_slave.v ***
`timescale 1ns/1ps
`include "ocgp_consts.vh"
// ****************************************
// AHB-Lite slave front end, zero wait states
// ****************************************
module ocgp_ahb_slave (
  input wire ref_clk,
  input wire rst,
  input wire hsel,
  input wire [15:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  output reg wr_en,
  output reg [15:0] wr_addr,
  output wire [15:0] rd_addr_now
);
  wire take = hsel & htrans[1] & hready;
  reg wr_pend;
  assign rd_addr_now = haddr;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
    end else begin
      if (hready) begin
        wr_pend <= take & hwrite;
      end
      if (take) begin
        wr_addr <= haddr;
      end
    end
  end
  always @* begin
    wr_en = wr_pend;
  end
endmodule

// *** verification/ocgp_pin_load.sv ***
`timescale 1ns/1ps
// ****
// Board loads on the five port pins
// ****
module ocgp_pin_load (
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic filter_pullup,
  input wire logic [4:0] ext_drive,
  output logic [4:0] pin_level
);
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (i == 2 && filter_pullup) pin_level[i] = 1'b1;
      else pin_level[i] = ext_drive[i];
    end
  end
endmodule

// *** verification/ocgp_port_sva.sv ***
`timescale 1ns/1ps
`include "ocgp_consts.vh"
// ****
// Port checker
// ****
module ocgp_port_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [4:0] pin_in,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic filter_pullup,
  input wire logic crystal_osc_en,
  input wire logic ceramic_osc_en
);
  logic ph_wr;
  logic [1:0] mode;
  wire take = hsel && htrans[1] && hready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Shadow of the power mode, updated where the design takes write data
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_wr <= 1'b0;
      mode <= `OCGP_MODE_RUN;
    end else begin
      if (hready) ph_wr <= take && hwrite && haddr == `OCGP_ADDR_MODE;
      if (hready && ph_wr) mode <= hwdata[1:0];
    end
  end
  rd_pin_a: assert property (take && !hwrite && haddr == `OCGP_ADDR_PIN_INPUT
    |=> hrdata == {27'h0, $past(pin_in, 2)}) else $error("pin read wrong");
  xt_own_a: assert property (crystal_osc_en |-> &pin_oe_n[1:0])
    else $error("crystal pins driven");
  cf_own_a: assert property (ceramic_osc_en |-> &pin_oe_n[4:3])
    else $error("ceramic pins driven");
  pull_float_a: assert property (filter_pullup |-> pin_oe_n[2])
    else $error("pull-up on driven pin");
  halt_freeze_a: assert property (mode == `OCGP_MODE_HALT && $past(mode) == mode
    |-> $stable(pin_out) && $stable(pin_oe_n) && $stable(filter_pullup))
    else $error("pins moved in halt");
  hold_free_a: assert property (mode == `OCGP_MODE_HOLD && $past(mode) == mode
    |-> !crystal_osc_en && !ceramic_osc_en) else $error("oscillator kept in hold");
  deep_cf_a: assert property (mode == `OCGP_MODE_DEEP && $past(mode) == mode
    |-> !ceramic_osc_en) else $error("ceramic kept in deep hold");
  deep_xt_a: assert property (mode == `OCGP_MODE_DEEP && $past(mode) == mode
    |-> $stable(crystal_osc_en)) else $error("crystal moved in deep hold");
  cover property (mode == `OCGP_MODE_HALT);
  cover property ($rose(crystal_osc_en));
  cover property ($rose(ceramic_osc_en));
endmodule

// *** verification/osc_shared_gpio_port_tb.sv ***
`timescale 1ns/1ps
`include "ocgp_consts.vh"
module osc_shared_gpio_port_tb;
  logic ref_clk, rst, hsel, hwrite, vco_clk;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, r;
  logic [4:0] ext_drive;
  wire hready, hresp, filter_pullup, crystal_osc_en, ceramic_osc_en;
  wire [31:0] hrdata;
  wire [4:0] pin_in, pin_out, pin_oe_n;
  int err_count, comparisons;
  logic p;
  ocgp_port i_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .pin_in, .pin_out,
    .pin_oe_n, .filter_pullup, .crystal_osc_en, .ceramic_osc_en, .vco_clk);
  ocgp_pin_load i_load (.pin_out, .pin_oe_n, .filter_pullup, .ext_drive,
    .pin_level(pin_in));
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) vco_clk <= ~vco_clk;
  // ****
  // Bus tasks and checks
  // ****
  task report_and_stop;
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        $display("[ERR] %0t bus hang", $time);
        report_and_stop;
      end
      @(posedge ref_clk);
    end
  endtask
  task xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rdc(input logic [15:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask
  // Registers update on the edge that ends the data phase, pins one edge later
  task settle;
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    ref_clk = 0; rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; vco_clk = 0; ext_drive = 5'h0c; err_count = 0; comparisons = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    chk(pin_oe_n, 5'h1f);
    chk(hresp, 0);
    rdc(`OCGP_ADDR_LATCH, 0);
    rdc(`OCGP_ADDR_DIRECTION, 0);
    rdc(`OCGP_ADDR_FUNC_SEL, 0);
    rdc(`OCGP_ADDR_OSC_CTRL, 0);
    rdc(`OCGP_ADDR_PIN_INPUT, 32'h0c);
    wr(`OCGP_ADDR_LATCH, 32'h15);
    settle;
    chk(pin_oe_n, 5'h1f);
    chk(filter_pullup, 1);
    wr(`OCGP_ADDR_DIRECTION, 32'h1f);
    settle;
    chk({pin_oe_n, pin_out, filter_pullup}, 11'h02a);
    rdc(`OCGP_ADDR_PIN_INPUT, 32'h15);
    wr(`OCGP_ADDR_OSC_CTRL, 32'h05);
    settle;
    chk({crystal_osc_en, pin_oe_n}, 6'h23);
    wr(`OCGP_ADDR_OSC_CTRL, 32'h8f);
    settle;
    chk({ceramic_osc_en, pin_oe_n}, 6'h3b);
    rdc(`OCGP_ADDR_PIN_INPUT, 32'h0c);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_HOLD);
    settle;
    chk({crystal_osc_en, ceramic_osc_en, pin_oe_n}, 7'h00);
    wr(`OCGP_ADDR_LATCH, 32'h00);
    settle;
    chk(pin_out[2], 1);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_RUN);
    wr(`OCGP_ADDR_LATCH, 32'h15);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_DEEP);
    settle;
    chk({crystal_osc_en, ceramic_osc_en}, 2'h2);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_RUN);
    wr(`OCGP_ADDR_OSC_CTRL, 32'h00);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_HALT);
    wr(`OCGP_ADDR_LATCH, 32'h0a);
    wr(`OCGP_ADDR_DIRECTION, 32'h00);
    settle;
    chk({pin_oe_n, pin_out}, 10'h015);
    wr(`OCGP_ADDR_MODE, `OCGP_MODE_RUN);
    // VCO pin follows the clock with latch 0, goes high with latch 1 and floats as an input
    wr(`OCGP_ADDR_LATCH, 32'h00);
    wr(`OCGP_ADDR_FUNC_SEL, 32'h10);
    wr(`OCGP_ADDR_DIRECTION, 32'h10);
    settle;
    p = pin_out[4];
    @(posedge ref_clk);
    chk({pin_oe_n[4], pin_out[4]}, {1'b0, ~p});
    wr(`OCGP_ADDR_LATCH, 32'h10);
    settle;
    chk({pin_oe_n[4], pin_out[4]}, 2'h1);
    wr(`OCGP_ADDR_DIRECTION, 32'h00);
    settle;
    chk(pin_oe_n[4], 1);
    rdc(16'h7fe0, 0);
    report_and_stop;
  end
endmodule
bind ocgp_port ocgp_port_sva i_sva (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .pin_in, .pin_out, .pin_oe_n, .filter_pullup,
  .crystal_osc_en, .ceramic_osc_en);
